/* File: rtl/tx_transparency_pkg.sv */
package tx_transparency_pkg;
  // register offsets of the parallel port
  localparam logic [7:0] ADDR_MASK_LOW = 8'h39;
  localparam logic [7:0] ADDR_MASK_MID = 8'h3A;
  localparam logic [7:0] ADDR_MASK_HIGH = 8'h3B;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam int NUM_CHANNELS = 24;
  localparam int BITS_PER_CHANNEL = 8;
  localparam logic [4:0] LAST_CHANNEL = 5'h17;
  // bit positions within a channel byte, msb first on the line (bit 1 = msb)
  localparam int ROBBED_BIT_POS = 0;
  localparam int STUFF_BIT_POS = 1;
  localparam int YELLOW_BIT_POS = 6;
  // state of the per-channel pipeline
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01
  } pipe_state_t;
endpackage : tx_transparency_pkg

/* File: rtl/tx_transparency.sv */
`timescale 1ns/1ps
module tx_transparency
  import tx_transparency_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // framing controls
  input wire logic d4_mode,
  input wire logic yellow_tx,
  input wire logic stuffing_override_bit_a,
  input wire logic stuffing_override_bit_b,
  // channel byte stream
  input wire logic byte_valid,
  input wire logic [4:0] byte_channel,
  input wire logic [7:0] byte_data,
  input wire logic signaling_slot,
  input wire logic signaling_bit,
  input wire logic stuff_needed,
  output logic out_valid,
  output logic [4:0] out_channel,
  output logic [7:0] out_data,
  output logic out_clear,
  output logic timeslot_one_flag,
  output logic timeslot_last_flag
);

  logic [NUM_CHANNELS-1:0] mask_r;
  logic [7:0] data_nxt;
  logic [7:0] robbed_nxt;
  logic [7:0] read_nxt;
  logic clear_nxt;
  logic override_nxt;
  pipe_state_t state_r;

  // channel index inside the frame
  function automatic logic chan_in_range(input logic [4:0] ch);
    chan_in_range = (ch < NUM_CHANNELS[4:0]);
  endfunction : chan_in_range

  // mask bit lookup for a channel index
  function automatic logic chan_clear(input logic [NUM_CHANNELS-1:0] m,
                                      input logic [4:0] ch);
    chan_clear = chan_in_range(ch) ? m[ch] : 1'b0;
  endfunction : chan_clear

  // both override bits must be set
  function automatic logic override_on(input logic bit_a, input logic bit_b);
    override_on = bit_a && bit_b;
  endfunction : override_on

  // robbed-bit insertion only on channels that are not clear
  function automatic logic robbed_applies(input logic clear, input logic slot);
    robbed_applies = !clear && slot;
  endfunction : robbed_applies

  // stuffing of an all-zero byte, mask bypassed by the override
  function automatic logic stuff_applies(input logic clear, input logic ovr,
                                         input logic need, input logic [7:0] d);
    stuff_applies = need && (d == 8'h00) && (!clear || ovr);
  endfunction : stuff_applies

  // yellow alarm bit only forced in d4 framing
  function automatic logic yellow_applies(input logic d4, input logic yel);
    yellow_applies = d4 && yel;
  endfunction : yellow_applies

  // first timeslot of the frame
  function automatic logic is_first(input logic [4:0] ch);
    is_first = (ch == 5'h00);
  endfunction : is_first

  // last timeslot of the frame
  function automatic logic is_last(input logic [4:0] ch);
    is_last = (ch == LAST_CHANNEL);
  endfunction : is_last

  // register writes, one byte per third of the mask
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_mask
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          mask_r[g*8 +: 8] <= MASK_RESET;
        end else if (reg_wr && reg_addr == ADDR_MASK_LOW + 8'(g)) begin
          mask_r[g*8 +: 8] <= reg_wdata;
        end
      end
    end
  endgenerate

  // read data selection
  always_comb begin
    read_nxt = 8'h00;
    case (reg_addr)
      ADDR_MASK_LOW: read_nxt = mask_r[7:0];
      ADDR_MASK_MID: read_nxt = mask_r[15:8];
      ADDR_MASK_HIGH: read_nxt = mask_r[23:16];
      default: read_nxt = 8'h00;
    endcase
  end

  // register reads
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= read_nxt;
    end
  end

  // override decode
  always_comb begin
    override_nxt = override_on(stuffing_override_bit_a, stuffing_override_bit_b);
  end

  // channel clear lookup
  always_comb begin
    clear_nxt = chan_clear(mask_r, byte_channel);
  end

  // robbed-bit signaling insertion
  always_comb begin
    robbed_nxt = byte_data;
    if (robbed_applies(clear_nxt, signaling_slot)) begin
      robbed_nxt[ROBBED_BIT_POS] = signaling_bit;
    end
  end

  // bit 7 stuffing, then the yellow alarm bit
  always_comb begin
    data_nxt = robbed_nxt;
    if (stuff_applies(clear_nxt, override_nxt, stuff_needed, robbed_nxt)) begin
      data_nxt[STUFF_BIT_POS] = 1'b1;
    end
    if (yellow_applies(d4_mode, yellow_tx)) begin
      data_nxt[YELLOW_BIT_POS] = 1'b0;
    end
  end

  // pipeline state
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: if (byte_valid) state_r <= ST_RUN;
        ST_RUN: state_r <= ST_RUN;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // output valid, one cycle after the input byte
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      out_valid <= 1'b0;
    end else begin
      out_valid <= byte_valid;
    end
  end

  // output channel, same timeslot as the input
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      out_channel <= 5'h00;
    end else if (byte_valid) begin
      out_channel <= byte_channel;
    end
  end

  // output byte
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      out_data <= 8'h00;
    end else if (byte_valid) begin
      out_data <= data_nxt;
    end
  end

  // clear marker of the output byte
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      out_clear <= 1'b0;
    end else if (byte_valid) begin
      out_clear <= clear_nxt;
    end
  end

  // first timeslot marker
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      timeslot_one_flag <= 1'b0;
    end else if (byte_valid) begin
      timeslot_one_flag <= is_first(byte_channel);
    end
  end

  // last timeslot marker
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      timeslot_last_flag <= 1'b0;
    end else if (byte_valid) begin
      timeslot_last_flag <= is_last(byte_channel);
    end
  end

endmodule : tx_transparency

/* File: dv/frame_src.sv */
`timescale 1ns/1ps
module frame_src (input logic clk_sys, go, zero, output logic byte_valid = 0,
  output logic [4:0] byte_channel = 0, output logic [7:0] byte_data);
  // all-zero bytes exercise the stuffing path
  assign byte_data = zero ? 8'h00 : {byte_channel, 3'h5};
  always @(posedge clk_sys) begin
    byte_valid <= go || (byte_valid && byte_channel != 5'h17);
    byte_channel <= byte_valid ? byte_channel + 5'h01 : 5'h00;
  end
endmodule : frame_src

/* File: dv/tx_transparency_asserts.sv */
`timescale 1ns/1ps
module tx_transparency_asserts import tx_transparency_pkg::*; (
  input logic clk_sys, sys_rst, byte_valid, d4_mode, yellow_tx, signaling_slot,
  input logic signaling_bit, out_valid, out_clear, timeslot_one_flag, timeslot_last_flag,
  input logic stuff_needed, stuffing_override_bit_a, stuffing_override_bit_b,
  input logic [4:0] byte_channel, out_channel, input logic [7:0] byte_data, out_data);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_v; byte_valid |=> out_valid; endproperty
  a_v: assert property (p_v) else $error("lost");
  property p_i; !byte_valid |=> !out_valid; endproperty
  a_i: assert property (p_i) else $error("extra");
  property p_c; byte_valid |=> out_channel == $past(byte_channel); endproperty
  a_c: assert property (p_c) else $error("slot");
  property p_y; byte_valid && d4_mode && yellow_tx |=> !out_data[6]; endproperty
  a_y: assert property (p_y) else $error("yellow");
  property p_r; byte_valid && signaling_slot ##1 !out_clear |-> out_data[0] == $past(signaling_bit);
  endproperty
  a_r: assert property (p_r) else $error("robbed");
  property p_p; byte_valid && !d4_mode && byte_data != 0 ##1 out_clear
    |-> out_data == $past(byte_data); endproperty
  a_p: assert property (p_p) else $error("clear");
  property p_o; out_valid |-> timeslot_one_flag == (out_channel == 0); endproperty
  a_o: assert property (p_o) else $error("first");
  property p_l; out_valid |-> timeslot_last_flag == (out_channel == LAST_CHANNEL); endproperty
  a_l: assert property (p_l) else $error("last");
  property p_s; byte_valid && stuff_needed && byte_data == 0 && stuffing_override_bit_a &&
    stuffing_override_bit_b && !(signaling_slot && signaling_bit) |=> out_data[1]; endproperty
  a_s: assert property (p_s) else $error("override stuffing");
  cover property (out_valid && out_clear);
  cover property (out_valid && !out_clear);
  cover property (byte_valid && d4_mode && yellow_tx);
endmodule : tx_transparency_asserts
bind tx_transparency tx_transparency_asserts tx_transparency_asserts_inst (.*);

/* File: dv/t1_tx_channel_transparency_tb.sv */
`timescale 1ns/1ps
module t1_tx_channel_transparency_tb;
  import tx_transparency_pkg::*;
  logic clk_sys = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, d4_mode = 0, yellow_tx = 0;
  logic go = 0, ovr = 0, zero = 0, byte_valid, out_valid, out_clear;
  logic [7:0] exp;
  logic [4:0] byte_channel, out_channel;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, byte_data, out_data;
  logic [23:0] mask = 24'h5A8001;
  int failures = 0, check_count = 0, cyc = 0;
  always #5 clk_sys = ~clk_sys;
  tx_transparency tx_transparency_inst (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .d4_mode, .yellow_tx, .stuffing_override_bit_a(ovr),
    .stuffing_override_bit_b(ovr), .byte_valid, .byte_channel, .byte_data, .out_data,
    .signaling_slot(1'b1), .signaling_bit(1'b0), .stuff_needed(1'b1), .out_valid,
    .out_channel, .out_clear, .timeslot_one_flag(), .timeslot_last_flag());
  frame_src frame_src_inst (.clk_sys, .go, .zero, .byte_valid, .byte_channel, .byte_data);
  task automatic chk(input logic ok);
    check_count++;
    if (!ok) begin
      failures++;
      $display("unexpected at %0t: mismatch", $time);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic t_regs();
    for (int i = 0; i < 3; i++) begin
      reg_addr <= ADDR_MASK_LOW + 8'(i);
      reg_wdata <= mask[8*i+:8];
      reg_wr <= 1;
      @(posedge clk_sys);
    end
    reg_wr <= 0;
    for (int j = 0; j < 4; j++) begin
      reg_addr <= ADDR_MASK_LOW + 8'(j);
      reg_rd <= 1;
      @(posedge clk_sys);
      reg_rd <= 0;
      @(posedge clk_sys);
      chk(reg_rdata === ((j < 3) ? mask[8*j+:8] : 8'h00));
    end
  endtask : t_regs
  task automatic t_frame(input logic d, y, o, z);
    d4_mode <= d;
    yellow_tx <= y;
    ovr <= o;
    zero <= z;
    go <= 1;
    @(posedge clk_sys);
    go <= 0;
    repeat (26) @(posedge clk_sys);
  endtask : t_frame
  always @(posedge clk_sys) begin
    if (out_valid) begin
      exp = zero ? ((!mask[out_channel] || ovr) ? 8'h02 : 8'h00)
                 : {out_channel, 2'b10, mask[out_channel]};
      if (d4_mode && yellow_tx) exp[6] = 1'b0;
      chk(out_clear === mask[out_channel]);
      chk(out_data === exp);
    end
    if (++cyc > 2000) chk(1'b0);
    if (cyc > 2000) tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 0;
    t_regs();
    t_frame(0, 0, 0, 0);
    t_frame(1, 1, 1, 0);
    t_frame(0, 0, 1, 0);
    t_frame(0, 0, 0, 1);
    t_frame(1, 1, 1, 1);
    tally_and_finish();
  end
endmodule : t1_tx_channel_transparency_tb
